// [logic/tw_dev.sv]
// Summary of operation
// - delay bits pick off, 250, 500, 1000 ms
// - power-up: delay ones, select and protect zero
// - select 00 off, else inputs one-three
// - write-protect set blocks every serial write
// - result is 8-bit code, 00 to FF
// - select 00 stops the converter and updates
// - first result within 488 ms of enable
// - result refreshes about every 10 ms
// - new select used at next conversion slot
// - update flag high whenever select is nonzero (converter on)
// - host polls flag before reading result
// - result read in progress holds off updates
// - chip select low aborts read, releases hold
// - transfers start with chip select high
// - chip select low ends transfer, releases line
// - data in at rise, out after fall
// - bytes travel least significant bit first
// - first byte is address and command
// - command top bit: 0 read, 1 write
// - single transfer: one data byte, then deselect
// - address increments after every data byte
// - address wraps from last register to first
`default_nettype none
module tw_dev
  import tw_pkg::*;
#(
  parameter int CONV_CYC = CONV_PERIOD_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  tw_link_if.dev          link,
  input  wire logic [7:0] analog_in_first,
  input  wire logic [7:0] analog_in_second,
  input  wire logic [7:0] analog_in_third,
  output logic      [1:0] input_select,
  output logic            converter_on,
  output logic            write_protect,
  output logic      [9:0] wdog_timeout_ms,
  output logic      [7:0] adc_result,
  output logic            conversion_update_flag
);
  localparam int CW = $clog2(CONV_CYC + 1);

  // ****************************************************************
  // pin sampling and edges
  // ****************************************************************
  logic [2:0] pins;
  logic       cs_q;
  logic       sclk_q;
  logic       io_q;
  logic       sclk_d_reg;
  logic       rise;
  logic       fall;

  tw_sync #(.W(3)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .d        ({link.cs, link.sclk, link.io}),
    .q        (pins)
  );
  assign {cs_q, sclk_q, io_q} = pins;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_q;
    end
  end
  assign rise = cs_q & sclk_q & ~sclk_d_reg;
  assign fall = cs_q & ~sclk_q & sclk_d_reg;

  // ****************************************************************
  // register state
  // ****************************************************************
  logic       wp_reg;
  logic [1:0] ais_reg;
  logic [1:0] td_reg;
  logic [7:0] adc_reg;
  logic       hold_reg;
  logic       pend_reg;
  logic [CW-1:0] conv_cnt_reg;

  // ****************************************************************
  // serial engine
  // ****************************************************************
  tw_dev_st_t st_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] out_reg;
  logic [6:0] addr_reg;
  logic       dir_wr_reg;
  logic       oe_reg;
  logic       io_out_reg;
  logic [7:0] in_byte;
  logic [6:0] addr_next;
  logic [7:0] rd_byte;
  logic       wr_en;
  logic       rd_load;
  logic       rd_done;

  assign in_byte   = {io_q, sh_reg[7:1]};
  assign addr_next = (addr_reg == ADDR_LAST) ? ADDR_FIRST : addr_reg + 7'h01;

  always_comb begin
    rd_byte = 8'h00;
    if (addr_reg == ADDR_CTRL) begin
      rd_byte[CTRL_WP_BIT] = wp_reg;
      rd_byte[CTRL_AIS_LSB +: 2] = ais_reg;
    end else if (addr_reg == ADDR_STAT) begin
      rd_byte[STAT_CU_BIT] = conversion_update_flag;
    end else if (addr_reg == ADDR_WDOG) begin
      rd_byte[WDOG_TD_LSB +: 2] = td_reg;
    end else if (addr_reg == ADDR_ADC) begin
      rd_byte = adc_reg;
    end
  end

  assign wr_en   = (st_reg == DS_DATA) & dir_wr_reg & rise & (bit_reg == 3'h7) & ~wp_reg;
  assign rd_load = (st_reg == DS_DATA) & ~dir_wr_reg & fall & (bit_reg == 3'h0);
  assign rd_done = (st_reg == DS_DATA) & ~dir_wr_reg & fall & (bit_reg == 3'h7);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg     <= DS_IDLE;
      bit_reg    <= 3'h0;
      sh_reg     <= 8'h00;
      out_reg    <= 8'h00;
      addr_reg   <= ADDR_FIRST;
      dir_wr_reg <= 1'b0;
      oe_reg     <= 1'b0;
      io_out_reg <= 1'b0;
    end else if (!cs_q) begin
      st_reg  <= DS_IDLE;
      bit_reg <= 3'h0;
      oe_reg  <= 1'b0;
    end else begin
      case (st_reg)
        DS_IDLE: begin
          st_reg  <= DS_CMD;
          bit_reg <= 3'h0;
        end
        DS_CMD: begin
          if (rise) begin
            sh_reg  <= in_byte;
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              addr_reg   <= in_byte[6:0];
              dir_wr_reg <= in_byte[CMD_DIR_BIT];
              st_reg     <= DS_DATA;
            end
          end
        end
        DS_DATA: begin
          if (dir_wr_reg && rise) begin
            sh_reg  <= in_byte;
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              addr_reg <= addr_next;
            end
          end else if (!dir_wr_reg && fall) begin
            bit_reg <= bit_reg + 3'h1;
            oe_reg  <= 1'b1;
            if (bit_reg == 3'h0) begin
              out_reg    <= rd_byte;
              io_out_reg <= rd_byte[0];
            end else begin
              io_out_reg <= out_reg[bit_reg];
            end
            if (bit_reg == 3'h7) begin
              addr_reg <= addr_next;
            end
          end
        end
        default: begin
          st_reg <= DS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // host-writable registers
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wp_reg  <= WP_RST;
      ais_reg <= INPUT_SEL_RST;
      td_reg  <= WDOG_DELAY_RST;
    end else if (wr_en) begin
      if (addr_reg == ADDR_CTRL) begin
        wp_reg  <= in_byte[CTRL_WP_BIT];
        ais_reg <= in_byte[CTRL_AIS_LSB +: 2];
      end else if (addr_reg == ADDR_WDOG) begin
        td_reg <= in_byte[WDOG_TD_LSB +: 2];
      end
    end
  end

  // ****************************************************************
  // converter sequencing
  // ****************************************************************
  logic slot;
  logic [7:0] sample;

  assign slot = (ais_reg != 2'h0) && (conv_cnt_reg == CW'(CONV_CYC - 1));

  // codes arrive already quantised: reference level FF, ground 00
  always_comb begin
    case (ais_reg)
      2'h1:    sample = analog_in_first;
      2'h2:    sample = analog_in_second;
      2'h3:    sample = analog_in_third;
      default: sample = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hold_reg <= 1'b0;
    end else if (!cs_q) begin
      hold_reg <= 1'b0;
    end else if (rd_load && addr_reg == ADDR_ADC) begin
      hold_reg <= 1'b1;
    end else if (rd_done) begin
      hold_reg <= 1'b0;
    end
  end

  // first slot comes one period after enable, well inside 488 ms
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      conv_cnt_reg <= '0;
    end else if (ais_reg == 2'h0 || slot) begin
      conv_cnt_reg <= '0;
    end else begin
      conv_cnt_reg <= conv_cnt_reg + CW'(1);
    end
  end

  // a slot during a held read is kept pending, not dropped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_reg <= 1'b0;
      adc_reg  <= 8'h00;
    end else if (ais_reg == 2'h0) begin
      pend_reg <= 1'b0;
    end else if (slot) begin
      pend_reg <= 1'b1;
    end else if (pend_reg && !hold_reg) begin
      pend_reg <= 1'b0;
      adc_reg  <= sample;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      input_select           <= INPUT_SEL_RST;
      converter_on           <= 1'b0;
      write_protect          <= WP_RST;
      wdog_timeout_ms        <= WDOG_1000_MS;
      adc_result             <= 8'h00;
      conversion_update_flag <= 1'b0;
    end else begin
      input_select           <= ais_reg;
      converter_on           <= (ais_reg != 2'h0);
      write_protect          <= wp_reg;
      adc_result             <= adc_reg;
      // high for as long as the converter is on, low while off
      conversion_update_flag <= (ais_reg != 2'h0);
      case (td_reg)
        2'h1:    wdog_timeout_ms <= WDOG_250_MS;
        2'h2:    wdog_timeout_ms <= WDOG_500_MS;
        2'h3:    wdog_timeout_ms <= WDOG_1000_MS;
        default: wdog_timeout_ms <= WDOG_OFF_MS;
      endcase
    end
  end

  assign link.dev_io_out = io_out_reg;
  assign link.dev_io_oe  = oe_reg;
endmodule
`default_nettype wire

// [logic/tw_pkg.sv]
`default_nettype none
package tw_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CORE_PERIOD_NS  = 5;
  localparam int SCLK_HALF_NS    = 500;
  localparam int SCLK_HALF_CYC   = (SCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int CS_SETUP_NS     = 2000;
  localparam int CS_SETUP_CYC    = (CS_SETUP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int CS_IDLE_NS      = 2000;
  localparam int CS_IDLE_CYC     = (CS_IDLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int CONV_PERIOD_MS  = 10;
  localparam int CONV_PERIOD_CYC = CONV_PERIOD_MS * 1000000 / CORE_PERIOD_NS;
  // ****************************************************************
  // device register map and fields
  // ****************************************************************
  localparam logic [6:0] ADDR_CTRL = 7'h0B;
  localparam logic [6:0] ADDR_STAT = 7'h0C;
  localparam logic [6:0] ADDR_WDOG = 7'h0D;
  localparam logic [6:0] ADDR_ADC  = 7'h0E;
  localparam logic [6:0] ADDR_LAST = ADDR_ADC;
  localparam logic [6:0] ADDR_FIRST = 7'h00;
  localparam int CTRL_WP_BIT  = 6;
  localparam int CTRL_AIS_LSB = 4;
  localparam int STAT_CU_BIT  = 7;
  localparam int WDOG_TD_LSB  = 0;
  localparam int CMD_DIR_BIT  = 7;
  localparam logic [1:0] WDOG_DELAY_RST = 2'h3;
  localparam logic [1:0] INPUT_SEL_RST  = 2'h0;
  localparam logic       WP_RST         = 1'b0;
  localparam logic [9:0] WDOG_OFF_MS  = 10'h000;
  localparam logic [9:0] WDOG_250_MS  = 10'h0FA;
  localparam logic [9:0] WDOG_500_MS  = 10'h1F4;
  localparam logic [9:0] WDOG_1000_MS = 10'h3E8;
  // ****************************************************************
  // host controller register map
  // ****************************************************************
  localparam logic [2:0] HREG_CMD   = 3'h0;
  localparam logic [2:0] HREG_LEN   = 3'h1;
  localparam logic [2:0] HREG_STAT  = 3'h2;
  localparam logic [2:0] HREG_DATA0 = 3'h4;
  localparam int         BURST_MAX  = 4;
  typedef enum logic [1:0] {DS_IDLE = 2'b00, DS_CMD = 2'b01, DS_DATA = 2'b11} tw_dev_st_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_SETUP = 3'b001, HS_HIGH = 3'b011,
    HS_LOW = 3'b010, HS_END = 3'b110, HS_GAP = 3'b111
  } tw_host_st_t;
endpackage
`default_nettype wire

// [logic/tw_link_if.sv]
`default_nettype none
interface tw_link_if;
  logic cs;
  logic sclk;
  logic host_io_out;
  logic host_io_oe;
  logic dev_io_out;
  logic dev_io_oe;
  logic io;
  // undriven line reads low
  assign io = dev_io_oe ? dev_io_out : (host_io_oe ? host_io_out : 1'b0);
  modport host (output cs, output sclk, output host_io_out, output host_io_oe, input io);
  modport dev  (input cs, input sclk, input io, output dev_io_out, output dev_io_oe);
endinterface
`default_nettype wire

// [logic/tw_sync.sv]
`default_nettype none
module tw_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // stage 1 feeds only stage 2; a change counts once stages 2 and 3 agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        q[i]   <= 1'b0;
      end else begin
        s1_reg <= d[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          q[i] <= s3_reg;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [logic/tw_host.sv]
`default_nettype none
module tw_host
  import tw_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  tw_link_if.host         link,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);
  // ****************************************************************
  // state
  // ****************************************************************
  tw_host_st_t st_reg;
  logic [9:0]  tim_reg;
  logic [5:0]  bitn_reg;
  logic [7:0]  cmd_reg;
  logic [1:0]  len_reg;
  logic [7:0]  buf_reg [BURST_MAX];
  logic        cs_reg;
  logic        sclk_reg;
  logic        io_out_reg;
  logic        io_oe_reg;
  logic        io_q;
  logic        start;
  logic        cap_en;
  logic [5:0]  total;
  logic [5:0]  nb;
  logic [5:0]  dbit;
  logic [5:0]  nbit;
  logic        is_rd;

  tw_sync #(.W(1)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .d        (link.io),
    .q        (io_q)
  );

  assign is_rd  = ~cmd_reg[CMD_DIR_BIT];
  assign start  = reg_wr && reg_addr == HREG_CMD && st_reg == HS_IDLE;
  // command byte plus len_reg + 1 data bytes, then deselect
  assign total  = {1'b0, len_reg, 3'b000} + 6'h10;
  assign nb     = bitn_reg + 6'h01;
  assign dbit   = bitn_reg - 6'h08;
  assign nbit   = nb - 6'h08;
  // sample just before the rise, after the device drove on the fall
  assign cap_en = st_reg == HS_LOW && tim_reg == 10'(SCLK_HALF_CYC - 1) && is_rd
                  && bitn_reg >= 6'h08;

  // ****************************************************************
  // link sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg     <= HS_IDLE;
      tim_reg    <= 10'h000;
      bitn_reg   <= 6'h00;
      cmd_reg    <= 8'h00;
      cs_reg     <= 1'b0;
      sclk_reg   <= 1'b0;
      io_out_reg <= 1'b0;
      io_oe_reg  <= 1'b0;
    end else begin
      tim_reg <= tim_reg + 10'h001;
      case (st_reg)
        HS_IDLE: begin
          tim_reg <= 10'h000;
          if (start) begin
            cmd_reg    <= reg_wdata;
            cs_reg     <= 1'b1;
            io_oe_reg  <= 1'b1;
            io_out_reg <= reg_wdata[0];
            bitn_reg   <= 6'h00;
            st_reg     <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          if (tim_reg == 10'(CS_SETUP_CYC - 1)) begin
            tim_reg  <= 10'h000;
            sclk_reg <= 1'b1;
            st_reg   <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tim_reg == 10'(SCLK_HALF_CYC - 1)) begin
            tim_reg  <= 10'h000;
            sclk_reg <= 1'b0;
            bitn_reg <= nb;
            if (nb == total) begin
              st_reg <= HS_END;
            end else begin
              st_reg <= HS_LOW;
              if (nb < 6'h08) begin
                io_out_reg <= cmd_reg[nb[2:0]];
              end else if (is_rd) begin
                io_oe_reg <= 1'b0;
              end else begin
                io_out_reg <= buf_reg[nbit[4:3]][nbit[2:0]];
              end
            end
          end
        end
        HS_LOW: begin
          if (tim_reg == 10'(SCLK_HALF_CYC - 1)) begin
            tim_reg  <= 10'h000;
            sclk_reg <= 1'b1;
            st_reg   <= HS_HIGH;
          end
        end
        HS_END: begin
          if (tim_reg == 10'(SCLK_HALF_CYC - 1)) begin
            tim_reg   <= 10'h000;
            cs_reg    <= 1'b0;
            io_oe_reg <= 1'b0;
            st_reg    <= HS_GAP;
          end
        end
        default: begin
          if (tim_reg == 10'(CS_IDLE_CYC - 1)) begin
            st_reg <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      len_reg <= 2'h0;
    end else if (reg_wr && reg_addr == HREG_LEN && st_reg == HS_IDLE) begin
      len_reg <= reg_wdata[1:0];
    end
  end

  for (genvar i = 0; i < BURST_MAX; i++) begin : g_buf
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        buf_reg[i] <= 8'h00;
      end else if (cap_en && dbit[4:3] == 2'(i)) begin
        buf_reg[i][dbit[2:0]] <= io_q;
      end else if (reg_wr && reg_addr == HREG_DATA0 + 3'(i) && st_reg == HS_IDLE) begin
        buf_reg[i] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == HREG_CMD) begin
      reg_rdata <= cmd_reg;
    end else if (reg_addr == HREG_LEN) begin
      reg_rdata <= {6'h00, len_reg};
    end else if (reg_addr == HREG_STAT) begin
      reg_rdata <= {7'h00, st_reg != HS_IDLE};
    end else if (reg_addr >= HREG_DATA0) begin
      reg_rdata <= buf_reg[reg_addr[1:0]];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign link.cs          = cs_reg;
  assign link.sclk        = sclk_reg;
  assign link.host_io_out = io_out_reg;
  assign link.host_io_oe  = io_oe_reg;
endmodule
`default_nettype wire

// [dv/tw_checker.sv]
`default_nettype none
module tw_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cs,
  input wire logic sclk,
  input wire logic host_io_out,
  input wire logic host_io_oe,
  input wire logic dev_io_out,
  input wire logic dev_io_oe,
  input wire logic io
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // frame tracking
  // ****
  logic       sclk_q;
  logic [4:0] rises;
  logic [7:0] cmd;
  logic [8:0] stable;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclk_q <= 1'h0;
      stable <= 9'h000;
    end else begin
      sclk_q <= sclk;
      stable <= (sclk != sclk_q) ? 9'h000 : stable + {8'h00, stable != 9'h1FF};
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) rises <= 5'h00;
    else if (!cs) rises <= 5'h00;
    else if (sclk && !sclk_q && rises != 5'h1F) rises <= rises + 5'h01;
  end
  // lsb first, so the direction bit ends on top
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) cmd <= 8'h00;
    else if (cs && sclk && !sclk_q && rises < 5'h08) cmd <= {io, cmd[7:1]};
  end
  // ****
  // link checks
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_sclk_half_period: assert property (sclk != sclk_q |-> stable >= 9'h063)
    else $error("serial clock half period short");
  a_idle_clock_low: assert property (!cs |-> !sclk)
    else $error("serial clock high while deselected");
  a_cs_setup_time: assert property ($rose(cs) |-> !sclk [*8])
    else $error("clock rose too soon after select");
  a_release_line: assert property ($fell(cs) |-> ##[0:8] !dev_io_oe)
    else $error("line not released after deselect");
  a_drive_start: assert property ($rose(dev_io_oe) |-> cs && !sclk && rises == 5'h08 && !cmd[7])
    else $error("device drive began at wrong point");
  a_write_quiet: assert property (rises >= 5'h08 && cmd[7] |-> !dev_io_oe)
    else $error("device drove during write");
  a_read_holds: assert property (dev_io_oe && cs |=> dev_io_oe)
    else $error("device dropped line while selected");
  a_out_on_low: assert property (dev_io_oe && $past(dev_io_oe) && $changed(dev_io_out) |-> !sclk)
    else $error("device data moved while clock high");
  a_host_cmd_bits: assert property (sclk && !sclk_q && rises < 5'h08 |-> host_io_oe && io == host_io_out)
    else $error("command bit not from host");
endmodule
`default_nettype wire

// [dv/tb.sv]
`default_nettype none
module tb
  import tw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = 200;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] val;
    logic [9:0] ms;
    logic [7:0] adc;
    logic       on;
  } tw_row_t;
  // ****
  // ordinary cases: delay codes, then each input select
  // ****
  tw_row_t rows [8] = '{
    '{ADDR_WDOG, 8'h00, 10'h000, 8'h00, 1'h0}, '{ADDR_WDOG, 8'h01, 10'h0FA, 8'h00, 1'h0},
    '{ADDR_WDOG, 8'h02, 10'h1F4, 8'h00, 1'h0}, '{ADDR_WDOG, 8'h03, 10'h3E8, 8'h00, 1'h0},
    '{ADDR_CTRL, 8'h10, 10'h3E8, 8'hFF, 1'h1}, '{ADDR_CTRL, 8'h20, 10'h3E8, 8'h00, 1'h1},
    '{ADDR_CTRL, 8'h30, 10'h3E8, 8'h5A, 1'h1}, '{ADDR_CTRL, 8'h00, 10'h3E8, 8'h5A, 1'h0}};
  logic        core_clk, converter_on, write_protect, flag;
  logic        reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, adc_result;
  logic [7:0]  analog_in_first = 8'hFF, analog_in_second = 8'h00, analog_in_third = 8'h5A;
  logic [1:0]  input_select;
  logic [9:0]  wdog_ms;
  logic [31:0] rd;
  int          num_errors = 0, checks_done = 0, cycles = 0;
  tw_link_if tw_link_if_i ();
  tw_dev #(.CONV_CYC(CONV)) tw_dev_i (.core_clk(core_clk), .reset(reset), .link(tw_link_if_i),
    .analog_in_first(analog_in_first), .analog_in_second(analog_in_second),
    .analog_in_third(analog_in_third), .input_select(input_select), .converter_on(converter_on),
    .write_protect(write_protect), .wdog_timeout_ms(wdog_ms), .adc_result(adc_result),
    .conversion_update_flag(flag));
  tw_host tw_host_i (.core_clk(core_clk), .reset(reset), .link(tw_link_if_i), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  tw_checker tw_checker_i (.core_clk(core_clk), .reset(reset), .cs(tw_link_if_i.cs),
    .sclk(tw_link_if_i.sclk), .host_io_out(tw_link_if_i.host_io_out),
    .host_io_oe(tw_link_if_i.host_io_oe), .dev_io_out(tw_link_if_i.dev_io_out),
    .dev_io_oe(tw_link_if_i.dev_io_oe), .io(tw_link_if_i.io));
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ****
  // shared tasks
  // ****
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  // one frame: len is data bytes minus one, bytes in burst order
  task automatic xfer(input logic [7:0] cmd, input logic [1:0] len, input logic [31:0] wd);
    logic [7:0] s;
    int         k;
    bus_wr(HREG_LEN, {6'h00, len});
    for (int i = 0; i < 4; i++) bus_wr(HREG_DATA0 + 3'(i), wd[8*i+:8]);
    bus_wr(HREG_CMD, cmd);
    s = 8'h01;
    for (k = 0; k < 8000 && s[0] !== 1'h0; k++) bus_rd(HREG_STAT, s);
    check("frame done", s, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bus_rd(HREG_DATA0 + 3'(i), s);
      rd[8*i+:8] = s;
    end
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'h1;
    repeat (2) @(posedge core_clk);
    reset <= 1'h0;
    #1;
    check("reset state", {wdog_ms, input_select, write_protect}, 13'h1F40);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 104000) begin
      num_errors++;
      complete_run();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    do_reset();
    xfer({1'h0, ADDR_CTRL}, 2'h2, 32'h0000_0000);
    check("ctrl bits", rd[6:4], 3'h0);
    check("wdog reg", rd[23:16], {6'h00, WDOG_DELAY_RST});
    foreach (rows[i]) begin
      xfer({1'h1, rows[i].addr}, 2'h0, {24'h00_0000, rows[i].val});
      xfer({1'h0, ADDR_ADC}, 2'h0, 32'h0000_0000);
      check("adc byte", rd[7:0], rows[i].adc);
      check("adc port", adc_result, rows[i].adc);
      check("wdog ms", wdog_ms, rows[i].ms);
      check("conv on", {converter_on, flag}, {2{rows[i].on}});
    end
    @(posedge core_clk);
    analog_in_third <= 8'hA5;
    repeat (3 * CONV) @(posedge core_clk);
    check("adc held", adc_result, 8'h5A);
    xfer({1'h1, ADDR_WDOG}, 2'h1, 32'h0000_7702);
    check("burst ms", wdog_ms, 10'h1F4);
    xfer({1'h0, ADDR_STAT}, 2'h3, 32'h0000_0000);
    check("wrap addr", tw_dev_i.addr_reg, 7'h01);
    check("status", rd[7], 1'h0);
    check("burst", rd[23:8], 16'h5A02);
    check("wrapped", rd[31:24], 8'h00);
    xfer({1'h1, ADDR_CTRL}, 2'h0, 32'h0000_0040);
    xfer({1'h1, ADDR_WDOG}, 2'h0, 32'h0000_0001);
    xfer({1'h1, ADDR_CTRL}, 2'h0, 32'h0000_0000);
    check("protected", {write_protect, wdog_ms}, 11'h5F4);
    do_reset();
    complete_run();
  end
endmodule
`default_nettype wire
